// *** hdl/dsr_pkg.sv ***
// constants and types shared by the diagnostic status register block
package dsr_pkg;

  // ****************************************************************
  // register offsets and reset values
  // ****************************************************************
  localparam logic [5:0] DSR_AFE_OFF = 6'h0D;
  localparam logic [5:0] DSR_SYS_OFF = 6'h0E;
  localparam logic [15:0] DSR_AFE_RST = 16'h8000;
  localparam logic [15:0] DSR_SYS_RST = 16'h0000;
  localparam logic [15:0] DSR_AFE_RSVD_MASK = 16'h60FC;
  localparam logic [15:0] DSR_SYS_RSVD_MASK = 16'h00C0;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AFE_PWR_BIT = 15;
  localparam int AFE_SENS_BIT = 12;
  localparam int AFE_TEMP_BIT = 11;
  localparam int AFE_AXIS_LSB = 8;
  localparam int AFE_TRIM_BIT = 1;
  localparam int AFE_REG_BIT = 0;
  localparam int SYS_LVL_BIT = 15;
  localparam int SYS_IRQ_DRV_BIT = 14;
  localparam int SYS_SDO_BIT = 13;
  localparam int SYS_CRC_BIT = 12;
  localparam int SYS_FRAME_BIT = 11;
  localparam int SYS_OP_LSB = 8;
  localparam int SYS_OV_BIT = 5;
  localparam int SYS_UV_BIT = 4;
  localparam int SYS_TEMP_BIT = 3;
  localparam int SYS_AXIS_LSB = 0;

  // ****************************************************************
  // operating state codes and alert summary codes
  // ****************************************************************
  localparam logic [2:0] OP_CONFIG = 3'h0;
  localparam logic [2:0] OP_STANDBY = 3'h1;
  localparam logic [2:0] OP_CONT = 3'h2;
  localparam logic [2:0] OP_TRIG = 3'h3;
  localparam logic [2:0] OP_DC_ACTIVE = 3'h4;
  localparam logic [2:0] OP_DC_SLEEP = 3'h5;
  localparam logic [2:0] OP_SLEEP = 3'h6;
  localparam logic [1:0] SUM_NONE = 2'h0;
  localparam logic [1:0] SUM_AFE = 2'h1;
  localparam logic [1:0] SUM_SYS = 2'h2;
  localparam logic [1:0] SUM_BOTH = 2'h3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int IRQ_SETTLE_NS = 20;
  localparam int IRQ_SETTLE_CYC = (IRQ_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {DSR_CHK_IDLE, DSR_CHK_SETTLE, DSR_CHK_DONE} dsr_chk_t;

endpackage : dsr_pkg

// *** hdl/dsr_sticky_flags.sv ***
// bank of sticky flags, set by events and cleared on read
module dsr_sticky_flags
  import dsr_pkg::*;
#(
  parameter int W = 16,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] flags_r
);

  // refuse a bank the flag logic cannot hold
  if (W < 1) begin : g_bad_width
    $error("flag bank needs at least one bit");
  end

  // a set in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_r <= RST_VAL;
    end else begin
      flags_r <= (flags_r & ~clr_in) | set_in;
    end
  end

  set_wins_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (set_in != '0) |=> ((flags_r & $past(set_in)) == $past(set_in)))
    else $error("event lost against a clear");

endmodule : dsr_sticky_flags

// *** hdl/dsr_status_regs.sv ***
// front end diagnostic and system status registers with clear-on-read
// Behaviour
// - power-up flag set by reset, read clears
// - front end sensor fault latches bit 12
// - temperature sensor fault latches bit 11
// - axis sensor faults latch bits 10..8
// - trim data error latches bit 1
// - regulator fault latches bit 0
// - bit 15 shows interrupt pin level
// - interrupt pin not going low flags bit 14
// - serial out feedback mismatch flags bit 13
// - crc error latches bit 12
// - bad clock count latches bit 11
// - bits 10..8 report operating state
// - over-voltage in active/standby latches bit 5
// - under-voltage in active/standby latches bit 4
// - temperature limit crossing latches bit 3
// - axis limit crossings latch bits 2..0
// - alert summary: 1 front end, 2 system, 3 both
module dsr_status_regs
  import dsr_pkg::*;
#(
  parameter int SETTLE_CYC = IRQ_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_rd_en,
  input wire logic [5:0] reg_addr,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic front_end_sensor_fault,
  input wire logic temp_sensor_fault,
  input wire logic z_axis_sensor_fault,
  input wire logic y_axis_sensor_fault,
  input wire logic x_axis_sensor_fault,
  input wire logic trim_data_fault,
  input wire logic regulator_fault,
  input wire logic crc_error,
  input wire logic frame_error,
  input wire logic [2:0] op_state,
  input wire logic supply_over_voltage,
  input wire logic supply_under_voltage,
  input wire logic temp_limit_crossed,
  input wire logic z_limit_crossed,
  input wire logic y_limit_crossed,
  input wire logic x_limit_crossed,
  input wire logic irq_drive_req,
  input wire logic irq_pin_i,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  input wire logic serial_out_drive_fault_en,
  input wire logic serial_out_drive_fault_val,
  input wire logic sdo_pin_fb,
  output logic [1:0] irq_cause_summary
);

  localparam int CNT_W = $clog2(SETTLE_CYC + 1);

  // refuse a settle count the check state machine cannot count
  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("settle count must be at least one cycle");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic irq_fb_s1_r;
  logic irq_fb_s2_r;
  logic sdo_fb_s1_r;
  logic sdo_fb_s2_r;

  // feedback pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_fb_s1_r <= 1'b1;
      irq_fb_s2_r <= 1'b1;
      sdo_fb_s1_r <= 1'b0;
      sdo_fb_s2_r <= 1'b0;
    end else begin
      irq_fb_s1_r <= irq_pin_i;
      irq_fb_s2_r <= irq_fb_s1_r;
      sdo_fb_s1_r <= sdo_pin_fb;
      sdo_fb_s2_r <= sdo_fb_s1_r;
    end
  end

  // ****************************************************************
  // interrupt pin drive and low check
  // ****************************************************************
  logic irq_oe_r;
  logic irq_o_r;
  dsr_chk_t chk_r;
  logic [CNT_W-1:0] settle_cnt_r;
  logic irq_drv_fault_nxt;

  // open drain: only ever pulls low, oe follows the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_oe_r <= 1'b0;
      irq_o_r <= 1'b0;
    end else begin
      irq_oe_r <= irq_drive_req;
      irq_o_r <= 1'b0;
    end
  end

  // one check per drive, after the pin and synchroniser settle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chk_r <= DSR_CHK_IDLE;
      settle_cnt_r <= '0;
    end else begin
      case (chk_r)
        DSR_CHK_IDLE: begin
          settle_cnt_r <= '0;
          if (irq_oe_r) chk_r <= DSR_CHK_SETTLE;
        end
        DSR_CHK_SETTLE: begin
          settle_cnt_r <= settle_cnt_r + CNT_W'(1);
          if (!irq_oe_r) chk_r <= DSR_CHK_IDLE;
          else if (settle_cnt_r == CNT_W'(SETTLE_CYC - 1)) chk_r <= DSR_CHK_DONE;
        end
        DSR_CHK_DONE: begin
          if (!irq_oe_r) chk_r <= DSR_CHK_IDLE;
        end
        default: chk_r <= DSR_CHK_IDLE;
      endcase
    end
  end

  // pin still high at the end of the settle window is a drive fault
  assign irq_drv_fault_nxt = (chk_r == DSR_CHK_SETTLE) && irq_oe_r &&
                             (settle_cnt_r == CNT_W'(SETTLE_CYC - 1)) && irq_fb_s2_r;

  // ****************************************************************
  // serial out drive check
  // ****************************************************************
  logic sdo_en_d1_r;
  logic sdo_en_d2_r;
  logic sdo_val_d1_r;
  logic sdo_val_d2_r;
  logic sdo_mismatch;

  // delay the driven value to line up with the synchronised feedback
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sdo_en_d1_r <= 1'b0;
      sdo_en_d2_r <= 1'b0;
      sdo_val_d1_r <= 1'b0;
      sdo_val_d2_r <= 1'b0;
    end else begin
      sdo_en_d1_r <= serial_out_drive_fault_en;
      sdo_en_d2_r <= sdo_en_d1_r;
      sdo_val_d1_r <= serial_out_drive_fault_val;
      sdo_val_d2_r <= sdo_val_d1_r;
    end
  end

  assign sdo_mismatch = sdo_en_d2_r && (sdo_val_d2_r != sdo_fb_s2_r);

  // ****************************************************************
  // flag banks
  // ****************************************************************
  logic supply_window;
  logic rd_afe;
  logic rd_sys;
  logic [15:0] afe_set;
  logic [15:0] sys_set;
  logic [15:0] afe_q;
  logic [15:0] sys_q;
  logic [15:0] afe_clr;
  logic [15:0] sys_clr;
  logic [15:0] sys_word;

  // supply monitors only count while active or in standby
  assign supply_window = (op_state == OP_STANDBY) || (op_state == OP_CONT) ||
                         (op_state == OP_TRIG) || (op_state == OP_DC_ACTIVE);
  assign rd_afe = reg_rd_en && (reg_addr == DSR_AFE_OFF);
  assign rd_sys = reg_rd_en && (reg_addr == DSR_SYS_OFF);

  // event to bit mapping; reserved and live bits never set
  always_comb begin
    afe_set = '0;
    afe_set[AFE_SENS_BIT] = front_end_sensor_fault;
    afe_set[AFE_TEMP_BIT] = temp_sensor_fault;
    afe_set[AFE_AXIS_LSB + 2] = z_axis_sensor_fault;
    afe_set[AFE_AXIS_LSB + 1] = y_axis_sensor_fault;
    afe_set[AFE_AXIS_LSB] = x_axis_sensor_fault;
    afe_set[AFE_TRIM_BIT] = trim_data_fault;
    afe_set[AFE_REG_BIT] = regulator_fault;
    sys_set = '0;
    sys_set[SYS_IRQ_DRV_BIT] = irq_drv_fault_nxt;
    sys_set[SYS_SDO_BIT] = sdo_mismatch;
    sys_set[SYS_CRC_BIT] = crc_error;
    sys_set[SYS_FRAME_BIT] = frame_error;
    sys_set[SYS_OV_BIT] = supply_over_voltage && supply_window;
    sys_set[SYS_UV_BIT] = supply_under_voltage && supply_window;
    sys_set[SYS_TEMP_BIT] = temp_limit_crossed;
    sys_set[SYS_AXIS_LSB + 2] = z_limit_crossed;
    sys_set[SYS_AXIS_LSB + 1] = y_limit_crossed;
    sys_set[SYS_AXIS_LSB] = x_limit_crossed;
  end

  // clear mask is exactly the sticky bits the read returns; live level and state bits are not in it
  assign afe_clr = rd_afe ? afe_q : '0;
  assign sys_clr = rd_sys ? sys_q : '0;

  // power-up flag enters through the reset value only
  dsr_sticky_flags #(
    .W(16),
    .RST_VAL(DSR_AFE_RST)
  ) u_afe_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .set_in(afe_set),
    .clr_in(afe_clr),
    .flags_r(afe_q)
  );

  dsr_sticky_flags #(
    .W(16),
    .RST_VAL(DSR_SYS_RST)
  ) u_sys_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .set_in(sys_set),
    .clr_in(sys_clr),
    .flags_r(sys_q)
  );

  // live fields merged over the sticky ones; reserved stay zero
  always_comb begin
    sys_word = sys_q & ~DSR_SYS_RSVD_MASK;
    sys_word[SYS_LVL_BIT] = irq_fb_s2_r;
    sys_word[SYS_OP_LSB +: 3] = op_state;
  end

  // ****************************************************************
  // read port and summary
  // ****************************************************************
  logic [15:0] rd_data_r;
  logic rd_valid_r;
  logic [1:0] summary_r;

  // one cycle read latency; unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (rd_afe) rd_data_r <= afe_q & ~DSR_AFE_RSVD_MASK;
      else if (rd_sys) rd_data_r <= sys_word;
      else if (reg_rd_en) rd_data_r <= '0;
    end
  end

  // summary looks at sticky flags only, not live level or state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      summary_r <= SUM_NONE;
    end else begin
      summary_r <= {(sys_q != '0), (afe_q != '0)};
    end
  end

  assign reg_rd_data = rd_data_r;
  assign reg_rd_valid = rd_valid_r;
  assign irq_pin_o = irq_o_r;
  assign irq_pin_oe = irq_oe_r;
  assign irq_cause_summary = summary_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  pwr_flag_reset_a: assert property ($fell(rst) |-> afe_q[AFE_PWR_BIT])
    else $error("power-up flag not set after reset");
  pwr_flag_clear_a: assert property (rd_afe |=> !afe_q[AFE_PWR_BIT])
    else $error("power-up flag survived a read");
  sens_fault_set_a: assert property (front_end_sensor_fault |=> afe_q[AFE_SENS_BIT])
    else $error("front end fault not latched");
  temp_fault_set_a: assert property (temp_sensor_fault |=> afe_q[AFE_TEMP_BIT])
    else $error("temperature sensor fault not latched");
  axis_fault_set_a: assert property (
    z_axis_sensor_fault ##1 rd_afe |=> rd_data_r[AFE_AXIS_LSB + 2])
    else $error("z axis fault not returned");
  trim_fault_set_a: assert property (trim_data_fault |=> afe_q[AFE_TRIM_BIT])
    else $error("trim fault not latched");
  reg_fault_set_a: assert property (regulator_fault |=> afe_q[AFE_REG_BIT])
    else $error("regulator fault not latched");
  irq_level_read_a: assert property (
    rd_sys |=> rd_data_r[SYS_LVL_BIT] == $past(irq_fb_s2_r))
    else $error("pin level misreported");
  irq_drive_chk_a: assert property (
    (irq_drive_req && irq_pin_i) [*8] |=> sys_q[SYS_IRQ_DRV_BIT] || $past(rd_sys))
    else $error("stuck high pin not flagged");
  sdo_mismatch_a: assert property (
    $past(serial_out_drive_fault_en, 2) && ($past(serial_out_drive_fault_val, 2) != sdo_fb_s2_r) |=> sys_q[SYS_SDO_BIT])
    else $error("serial out mismatch not flagged");
  crc_flag_set_a: assert property (crc_error |=> sys_q[SYS_CRC_BIT])
    else $error("crc error not latched");
  frame_flag_set_a: assert property (frame_error |=> sys_q[SYS_FRAME_BIT])
    else $error("frame error not latched");
  op_state_read_a: assert property (
    rd_sys |=> rd_data_r[SYS_OP_LSB +: 3] == $past(op_state))
    else $error("operating state misreported");
  ov_gate_a: assert property (
    supply_over_voltage && (op_state == OP_SLEEP) && !sys_q[SYS_OV_BIT] |=> !sys_q[SYS_OV_BIT])
    else $error("over-voltage latched outside window");
  uv_flag_set_a: assert property (
    supply_under_voltage && (op_state == OP_STANDBY) |=> sys_q[SYS_UV_BIT])
    else $error("under-voltage not latched in standby");
  temp_cross_set_a: assert property (temp_limit_crossed |=> sys_q[SYS_TEMP_BIT])
    else $error("temperature crossing not latched");
  axis_cross_set_a: assert property (
    x_limit_crossed ##1 rd_sys |=> rd_data_r[SYS_AXIS_LSB])
    else $error("x crossing not returned");
  summary_code_a: assert property (
    (afe_q != '0) && (sys_q == '0) |=> summary_r == SUM_AFE)
    else $error("summary code wrong");
  clr_only_read_a: assert property (
    rd_sys && crc_error && !sys_q[SYS_CRC_BIT] |=> sys_q[SYS_CRC_BIT] && !rd_data_r[SYS_CRC_BIT])
    else $error("event lost in the clearing read");
  rsvd_zero_a: assert property (
    rd_afe |=> (rd_data_r & DSR_AFE_RSVD_MASK) == '0)
    else $error("reserved bits not zero");
  irq_oe_follow_a: assert property (!$past(rst) |-> irq_oe_r == $past(irq_drive_req))
    else $error("drive enable does not follow the request");
  irq_low_only_a: assert property (!irq_o_r)
    else $error("open drain output driven high");

  // covers for the main scenarios
  pwr_read_c: cover property ($fell(rst) ##[1:20] rd_afe);
  ov_sleep_c: cover property (supply_over_voltage && (op_state == OP_SLEEP));
  irq_fault_c: cover property (irq_drv_fault_nxt);
  sdo_fault_c: cover property (sdo_mismatch ##1 rd_sys);
  set_during_read_c: cover property (rd_sys && crc_error);

endmodule : dsr_status_regs

// *** testbench/dsr_pin_model.sv ***
// pin-level model of the interrupt and serial-out wires outside the block
module dsr_pin_model (
  input wire logic clk_sys,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe,
  input wire logic irq_stuck_hi,
  input wire logic serial_out_drive_fault_en,
  input wire logic serial_out_drive_fault_val,
  input wire logic sdo_flip,
  output logic irq_pin_i,
  output logic sdo_pin_fb
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // wire levels
  // ****************************************************************
  logic idle_r = 1'b0;

  // released serial line wanders, so a stale value never passes for a driven one
  always @(posedge clk_sys) begin
    idle_r <= ~idle_r;
  end

  // open-drain line with pull-up; a stuck line ignores the drive
  assign irq_pin_i = irq_stuck_hi | ~(irq_pin_oe & ~irq_pin_o);
  assign sdo_pin_fb = serial_out_drive_fault_en ? (serial_out_drive_fault_val ^ sdo_flip) : idle_r; // flip only on command
endmodule : dsr_pin_model

// *** testbench/dsr_status_regs_tb_top.sv ***
// self-checking bench for the diagnostic status registers
`define DSR_CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[ERR] %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

module dsr_status_regs_tb_top;
  import dsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam int AFE_POS [7] = '{12, 11, 10, 9, 8, 1, 0};
  localparam int SYS_POS [8] = '{12, 11, 5, 4, 3, 2, 1, 0};
  logic clk_sys, rst, rd_en, rd_valid, irq_req, irq_i, irq_o, irq_oe;
  logic sdo_en, sdo_val, sdo_fb, stuck, flip;
  logic [5:0] addr;
  logic [15:0] rd_data;
  logic [6:0] afe_ev;
  logic [7:0] sys_ev;
  logic [2:0] op_state;
  logic [1:0] summary;
  int n_fail = 0;
  int cmp_count = 0;

  dsr_status_regs u_dsr_status_regs (
    .clk_sys(clk_sys), .rst(rst), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
    .front_end_sensor_fault(afe_ev[0]), .temp_sensor_fault(afe_ev[1]),
    .z_axis_sensor_fault(afe_ev[2]), .y_axis_sensor_fault(afe_ev[3]),
    .x_axis_sensor_fault(afe_ev[4]), .trim_data_fault(afe_ev[5]),
    .regulator_fault(afe_ev[6]), .crc_error(sys_ev[0]), .frame_error(sys_ev[1]),
    .op_state(op_state), .supply_over_voltage(sys_ev[2]),
    .supply_under_voltage(sys_ev[3]), .temp_limit_crossed(sys_ev[4]),
    .z_limit_crossed(sys_ev[5]), .y_limit_crossed(sys_ev[6]),
    .x_limit_crossed(sys_ev[7]), .irq_drive_req(irq_req), .irq_pin_i(irq_i),
    .irq_pin_o(irq_o), .irq_pin_oe(irq_oe), .serial_out_drive_fault_en(sdo_en),
    .serial_out_drive_fault_val(sdo_val), .sdo_pin_fb(sdo_fb), .irq_cause_summary(summary)
  );

  dsr_pin_model u_dsr_pin_model (
    .clk_sys(clk_sys), .irq_pin_o(irq_o), .irq_pin_oe(irq_oe),
    .irq_stuck_hi(stuck), .serial_out_drive_fault_en(sdo_en), .serial_out_drive_fault_val(sdo_val),
    .sdo_flip(flip), .irq_pin_i(irq_i), .sdo_pin_fb(sdo_fb)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // inputs always move 1 ns after an edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // one read; valid must come exactly one cycle after the request
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    rd_en = 1'b1;
    addr = a;
    tick(1);
    rd_en = 1'b0;
    `DSR_CHK(rd_valid, 1'b1)
    `DSR_CHK(rd_data, e)
    tick(1);
  endtask : rchk

  // pin high, no sticky flags, present state
  function automatic logic [15:0] sysb();
    return {5'h10, op_state, 8'h00};
  endfunction : sysb

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // power-up flag, read clear, unmapped offset, summary ignores live fields
  task automatic t_reset();
    tick(1);
    `DSR_CHK(summary, SUM_AFE)
    rchk(DSR_AFE_OFF, DSR_AFE_RST);
    rchk(DSR_AFE_OFF, 16'h0000);
    rchk(6'h0F, 16'h0000);
    `DSR_CHK(summary, SUM_NONE)
    rchk(DSR_SYS_OFF, sysb());
    $display("test reset done");
  endtask : t_reset

  // every front end fault alone, then every system event alone
  task automatic t_events();
    for (int k = 0; k < 7; k++) begin
      afe_ev[k] = 1'b1;
      tick(1);
      afe_ev = '0;
      tick(2);
      `DSR_CHK(summary, SUM_AFE)
      rchk(DSR_AFE_OFF, 16'h0001 << AFE_POS[k]);
      rchk(DSR_AFE_OFF, 16'h0000);
    end
    op_state = OP_STANDBY;
    for (int k = 0; k < 8; k++) begin
      sys_ev[k] = 1'b1;
      tick(1);
      sys_ev = '0;
      tick(2);
      `DSR_CHK(summary, SUM_SYS)
      rchk(DSR_SYS_OFF, sysb() | (16'h0001 << SYS_POS[k]));
      rchk(DSR_SYS_OFF, sysb());
    end
    afe_ev[5] = 1'b1;
    sys_ev[7] = 1'b1;
    tick(1);
    afe_ev = '0;
    sys_ev = '0;
    tick(2);
    `DSR_CHK(summary, SUM_BOTH)
    rchk(DSR_AFE_OFF, 16'h0002);
    rchk(DSR_SYS_OFF, sysb() | 16'h0001);
    $display("test events done");
  endtask : t_events

  // every state code; supply flags only in the active or standby states
  task automatic t_state();
    for (int st = 0; st < 7; st++) begin
      op_state = 3'(st);
      sys_ev[2] = 1'b1;
      sys_ev[3] = 1'b1;
      tick(1);
      sys_ev = '0;
      tick(1);
      rchk(DSR_SYS_OFF, sysb() | ((st >= 1 && st <= 4) ? 16'h0030 : 16'h0000));
    end
    $display("test state done");
  endtask : t_state

  // event in the very cycle of the clearing read must survive it
  task automatic t_race();
    sys_ev[0] = 1'b1;
    rd_en = 1'b1;
    addr = DSR_SYS_OFF;
    tick(1);
    sys_ev = '0;
    rd_en = 1'b0;
    `DSR_CHK(rd_data, sysb())
    tick(1);
    rchk(DSR_SYS_OFF, sysb() | 16'h1000);
    rchk(DSR_SYS_OFF, sysb());
    $display("test race done");
  endtask : t_race

  // healthy drive, stuck pin, and a drive too short to be checked
  task automatic t_irq();
    irq_req = 1'b1;
    tick(1);
    `DSR_CHK(irq_oe, 1'b1)
    `DSR_CHK(irq_o, 1'b0)
    tick(4);
    rchk(DSR_SYS_OFF, sysb() & 16'h7FFF);
    tick(8);
    irq_req = 1'b0;
    tick(4);
    `DSR_CHK(irq_oe, 1'b0)
    rchk(DSR_SYS_OFF, sysb());
    stuck = 1'b1;
    irq_req = 1'b1;
    tick(12);
    irq_req = 1'b0;
    tick(2);
    rchk(DSR_SYS_OFF, sysb() | 16'h4000);
    irq_req = 1'b1;
    tick(3);
    irq_req = 1'b0;
    tick(4);
    rchk(DSR_SYS_OFF, sysb());
    stuck = 1'b0;
    $display("test irq done");
  endtask : t_irq

  // serial out feedback agreeing, then disagreeing for one cycle
  task automatic t_sdo();
    sdo_en = 1'b1;
    sdo_val = 1'b1;
    tick(3);
    sdo_val = 1'b0;
    tick(3);
    sdo_en = 1'b0;
    tick(4);
    rchk(DSR_SYS_OFF, sysb());
    sdo_en = 1'b1;
    flip = 1'b1;
    tick(1);
    sdo_en = 1'b0;
    flip = 1'b0;
    tick(4);
    rchk(DSR_SYS_OFF, sysb() | 16'h2000);
    $display("test sdo done");
  endtask : t_sdo

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    $display("[ERR] %0t: watchdog expired", $time);
    n_fail++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {rd_en, irq_req, sdo_en, sdo_val, stuck, flip} = '0;
    addr = '0;
    afe_ev = '0;
    sys_ev = '0;
    op_state = OP_CONFIG;
    tick(4);
    rst = 1'b0;
    t_reset();
    t_events();
    t_state();
    t_race();
    t_irq();
    t_sdo();
    end_of_test();
  end
endmodule : dsr_status_regs_tb_top
